/* hdl/axis_param_pkg.sv */
package axis_param_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, word addresses on the plain register port.
    localparam int REG_COUNT = 22;
    localparam logic [4:0] R_CTRL = 5'h00;
    localparam logic [4:0] R_STATUS = 5'h01;
    localparam logic [4:0] R_ORG_OFS = 5'h02;
    localparam logic [4:0] R_SEEK_SPD = 5'h03;
    localparam logic [4:0] R_APPR_SPD = 5'h04;
    localparam logic [4:0] R_COMP_SPD = 5'h05;
    localparam logic [4:0] R_SEEK_ACC = 5'h06;
    localparam logic [4:0] R_SEEK_DEC = 5'h07;
    localparam logic [4:0] R_HOLD_MS = 5'h08;
    localparam logic [4:0] R_MASK_AMT = 5'h09;
    localparam logic [4:0] R_COMP_VAL = 5'h0a;
    localparam logic [4:0] R_RET_SPD = 5'h0b;
    localparam logic [4:0] R_RET_ACC = 5'h0c;
    localparam logic [4:0] R_RET_DEC = 5'h0d;
    localparam logic [4:0] R_INCH_W = 5'h0e;
    localparam logic [4:0] R_JOG_SPD1 = 5'h0f;
    localparam logic [4:0] R_JOG_SPD2 = 5'h10;
    localparam logic [4:0] R_JOG_ACC = 5'h11;
    localparam logic [4:0] R_JOG_DEC = 5'h12;
    localparam logic [4:0] R_ENC_TYPE = 5'h13;
    localparam logic [4:0] R_ABS_OFS = 5'h14;
    localparam logic [4:0] R_POS = 5'h15;

    // Control register fields.
    localparam int F_SETUP = 0;
    localparam int F_ACC_SEL = 1;
    localparam int F_VIRTUAL = 2;
    localparam int F_START_DIR = 3;
    localparam int F_DETECT_DIR = 4;
    localparam int F_MODE_LO = 8;
    localparam int F_MODE_HI = 11;
    localparam int INCH_W = 16;
    localparam int HOLD_W = 16;

    localparam logic [3:0] MODE_MASK = 4'h9;
    localparam logic [3:0] MODE_HOLD = 4'hb;
    localparam logic ENC_INC = 1'b0;
    localparam logic ENC_ABS = 1'b1;
    localparam logic DIR_FWD = 1'b0;
    localparam logic DIR_REV = 1'b1;

    localparam logic [31:0] REG_RESET [REG_COUNT] = '{
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_2710,
        32'h0000_03e8, 32'h0000_03e8, 32'h0000_03e8, 32'h0000_03e8,
        32'h0000_0064, 32'h0000_2710, 32'h0000_0000, 32'h0000_2710,
        32'h0000_03e8, 32'h0000_03e8, 32'h0000_0000, 32'h0000_03e8,
        32'h0000_2710, 32'h0000_03e8, 32'h0000_03e8, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000};

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 100;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_SEEK = 9'h002,
        ST_HOLD = 9'h004,
        ST_MASK = 9'h008,
        ST_APPROACH = 9'h010,
        ST_COMP = 9'h020,
        ST_JOG = 9'h040,
        ST_INCH = 9'h080,
        ST_RETURN = 9'h100
    } seq_state_type;

endpackage

/* hdl/axis_link_if.sv */
`timescale 1ns/1ps
interface axis_link_if;
    logic restart;
    logic setup_load;
    logic enc_type_cfg;
    logic virtual_axis;
    logic drive_abs;
    logic enc_abs;
    logic mismatch;
    logic restore_req;
    logic origin_def;
    logic [31:0] origin_offset;
    logic [31:0] abs_offset;
    logic [31:0] abs_offset_eff;
    logic [31:0] backup_pos;
    logic [15:0] pos_delta;
    logic [31:0] present_pos;

    modport ctl (output restart, setup_load, enc_type_cfg, virtual_axis,
        drive_abs, origin_def, origin_offset, abs_offset, backup_pos,
        pos_delta, input enc_abs, mismatch, restore_req, present_pos,
        abs_offset_eff);
    modport enc_side (input restart, setup_load, enc_type_cfg,
        virtual_axis, drive_abs, output enc_abs, mismatch, restore_req);
    modport pos_side (input origin_def, origin_offset, abs_offset,
        enc_abs, restore_req, backup_pos, pos_delta, output present_pos,
        abs_offset_eff);
endinterface

/* hdl/enc_cfg.sv */
`timescale 1ns/1ps
module enc_cfg
    import axis_param_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    axis_link_if.enc_side lk
);
    logic boot, next_boot;
    logic latched, next_latched;
    logic restore, next_restore;
    logic mismatch, next_mismatch;
    logic load;

    // The type is taken at the first enabled edge after reset, at a
    // restart and at a setup apply; a plain register write never moves it.
    assign load = boot | lk.restart | lk.setup_load;

    always_comb begin
        next_boot = 1'b0;
        next_latched = load ? lk.enc_type_cfg : latched;
        next_restore = boot | lk.restart;
        // The drive's own motor type only raises a flag.
        next_mismatch = (latched == ENC_ABS) != lk.drive_abs;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            boot <= 1'b1;
            latched <= ENC_INC;
            restore <= 1'b0;
            mismatch <= 1'b0;
        end else if (ce) begin
            boot <= next_boot;
            latched <= next_latched;
            restore <= next_restore;
            mismatch <= next_mismatch;
        end
    end

    assign lk.enc_abs = latched & ~lk.virtual_axis;
    assign lk.restore_req = restore;
    assign lk.mismatch = mismatch;

    type_latch_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !load |=> latched == $past(latched))
        else $error("encoder type moved without a load");
endmodule

/* hdl/pos_track.sv */
`timescale 1ns/1ps
module pos_track
    import axis_param_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    axis_link_if.pos_side lk
);
    logic [31:0] pos, next_pos;
    logic [31:0] abs_eff, next_abs_eff;

    always_comb begin
        next_pos = pos + {{16{lk.pos_delta[15]}}, lk.pos_delta};
        next_abs_eff = abs_eff;
        if (lk.origin_def) begin
            next_pos = lk.origin_offset;
            next_abs_eff = lk.enc_abs ? lk.abs_offset : '0;
        end else if (lk.restore_req && lk.enc_abs) begin
            next_pos = lk.backup_pos;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pos <= '0;
            abs_eff <= '0;
        end else if (ce) begin
            pos <= next_pos;
            abs_eff <= next_abs_eff;
        end
    end

    assign lk.present_pos = pos;
    assign lk.abs_offset_eff = abs_eff;

    no_restore_a: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk.restore_req && !lk.enc_abs && !lk.origin_def
        |=> pos == $past(pos) + {{16{$past(lk.pos_delta[15])}},
        $past(lk.pos_delta)})
        else $error("incremental axis restored its position");
endmodule

/* hdl/axis_params.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module axis_params
    import axis_param_pkg::*;
#(
    parameter int cycles_per_ms = CYC_PER_MS
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic restart,
    input wire logic cmd_search,
    input wire logic cmd_return,
    input wire logic cmd_jog,
    input wire logic cmd_inch,
    input wire logic cmd_stop,
    input wire logic jog_dir,
    input wire logic jog_speed_sel,
    input wire logic move_done,
    input wire logic prox_pin,
    input wire logic origin_pin,
    input wire logic drive_abs_pin,
    input wire logic [15:0] pos_delta,
    input wire logic [31:0] backup_pos,
    input wire logic abs_capture,
    input wire logic [31:0] abs_capture_value,
    output logic prof_run,
    output logic prof_dist_mode,
    output logic prof_dir,
    output logic prof_acc_sel,
    output logic [31:0] prof_speed,
    output logic [31:0] prof_acc,
    output logic [31:0] prof_dec,
    output logic [31:0] prof_dist,
    output logic origin_defined,
    output logic enc_abs,
    output logic [31:0] present_pos,
    output logic [31:0] abs_offset_active
);
    if (cycles_per_ms < 1) begin : g_chk
        $error("cycles_per_ms must be at least one");
    end

    axis_link_if lk ();
    enc_cfg u_enc (.clk_sys(clk_sys), .srst(srst), .ce(ce), .lk(lk));
    pos_track u_pos (.clk_sys(clk_sys), .srst(srst), .ce(ce), .lk(lk));

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: the first stage feeds only the second.
    logic [2:0] pin_s1, pin_s2;
    logic prox_s, origin_s;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (ce) begin
            pin_s1 <= {drive_abs_pin, origin_pin, prox_pin};
            pin_s2 <= pin_s1;
        end
    end
    assign prox_s = pin_s2[0];
    assign origin_s = pin_s2[1];

    ////////////////////////////////////////////////////////////////////////
    // Register file.
    logic [31:0] regs [REG_COUNT];
    logic [31:0] next_regs [REG_COUNT];
    logic [31:0] next_rdata, rd_word;
    logic wr_ok, setup_load;
    logic [3:0] mode;
    seq_state_type state, next_state;

    assign wr_ok = wr && addr < 5'(REG_COUNT) && addr != R_STATUS
        && addr != R_POS;
    assign setup_load = ce && wr && addr == R_CTRL && wdata[F_SETUP];
    assign mode = regs[R_CTRL][F_MODE_HI:F_MODE_LO];

    always_comb begin
        next_regs = regs;
        if (wr_ok) begin
            next_regs[addr] = wdata;
        end
        // A capture in the same cycle as a bus write wins.
        if (abs_capture) begin
            next_regs[R_ABS_OFS] = abs_capture_value;
        end
        next_regs[R_CTRL][F_SETUP] = 1'b0;
        rd_word = '0;
        if (addr == R_STATUS) begin
            rd_word = {20'h0_0000, lk.mismatch, lk.enc_abs, origin_defined,
                state};
        end else if (addr == R_POS) begin
            rd_word = lk.present_pos;
        end else if (addr < 5'(REG_COUNT)) begin
            rd_word = regs[addr];
        end
        next_rdata = rd ? rd_word : '0;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regs <= REG_RESET;
            rdata <= '0;
        end else if (ce) begin
            regs <= next_regs;
            rdata <= next_rdata;
        end
    end

    assign lk.restart = ce & restart;
    assign lk.setup_load = setup_load;
    assign lk.enc_type_cfg = regs[R_ENC_TYPE][0];
    assign lk.virtual_axis = regs[R_CTRL][F_VIRTUAL];
    assign lk.drive_abs = pin_s2[2];
    assign lk.origin_offset = regs[R_ORG_OFS];
    assign lk.abs_offset = regs[R_ABS_OFS];
    assign lk.backup_pos = backup_pos;
    assign lk.pos_delta = ce ? pos_delta : '0;
    assign enc_abs = lk.enc_abs;
    assign present_pos = lk.present_pos;
    assign abs_offset_active = lk.abs_offset_eff;

    ////////////////////////////////////////////////////////////////////////
    // Origin search, return and jog sequencer.
    logic [31:0] ms_cnt, next_ms_cnt;
    logic [HOLD_W-1:0] hold_ms, next_hold_ms;
    logic hold_done, next_origin_defined;
    logic [INCH_W-1:0] inch_w;

    assign hold_done = hold_ms >= regs[R_HOLD_MS][HOLD_W-1:0];
    assign inch_w = regs[R_INCH_W][INCH_W-1:0];
    assign lk.origin_def = ce && state == ST_APPROACH && origin_s;

    always_comb begin
        next_state = state;
        next_ms_cnt = '0;
        next_hold_ms = '0;
        next_origin_defined = origin_defined | lk.origin_def;
        unique case (state)
            ST_IDLE: begin
                if (cmd_stop) begin
                    next_state = ST_IDLE;
                end else if (cmd_search) begin
                    next_state = ST_SEEK;
                    next_origin_defined = 1'b0;
                end else if (cmd_return && origin_defined) begin
                    next_state = ST_RETURN;
                end else if (cmd_jog || (cmd_inch && inch_w == '0)) begin
                    next_state = ST_JOG;
                end else if (cmd_inch) begin
                    next_state = ST_INCH;
                end
            end
            ST_SEEK: begin
                if (prox_s) begin
                    if (mode == MODE_HOLD) begin
                        next_state = ST_HOLD;
                    end else if (mode == MODE_MASK) begin
                        next_state = ST_MASK;
                    end else begin
                        next_state = ST_APPROACH;
                    end
                end
            end
            ST_HOLD: begin
                next_ms_cnt = ms_cnt + 32'h0000_0001;
                next_hold_ms = hold_ms;
                if (ms_cnt == 32'(cycles_per_ms - 1)) begin
                    next_ms_cnt = '0;
                    next_hold_ms = hold_ms + 16'h0001;
                end
                if (hold_done) begin
                    next_state = ST_APPROACH;
                end
            end
            ST_MASK: if (move_done) begin
                next_state = ST_APPROACH;
            end
            ST_APPROACH: if (origin_s) begin
                next_state = ST_COMP;
            end
            ST_COMP: begin
                if (regs[R_COMP_VAL] == '0 || move_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_JOG: if (!cmd_jog && !cmd_inch) begin
                next_state = ST_IDLE;
            end
            ST_INCH, ST_RETURN: if (move_done) begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (cmd_stop) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            ms_cnt <= '0;
            hold_ms <= '0;
            origin_defined <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            ms_cnt <= next_ms_cnt;
            hold_ms <= next_hold_ms;
            origin_defined <= next_origin_defined;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Profile command. Speed and ramp registers are read live every cycle,
    // so a change reaches a move already in progress.
    logic n_run, n_dist_mode, n_dir;
    logic [31:0] n_speed, n_acc, n_dec, n_dist, comp, pos;

    assign comp = regs[R_COMP_VAL];
    assign pos = lk.present_pos;

    always_comb begin
        n_run = 1'b1;
        n_dist_mode = 1'b0;
        n_dir = regs[R_CTRL][F_DETECT_DIR];
        n_speed = regs[R_APPR_SPD];
        n_acc = regs[R_SEEK_ACC];
        n_dec = regs[R_SEEK_DEC];
        n_dist = '0;
        unique case (state)
            ST_SEEK: begin
                n_dir = regs[R_CTRL][F_START_DIR];
                n_speed = regs[R_SEEK_SPD];
            end
            ST_HOLD: n_run = 1'b0;
            ST_MASK: begin
                n_dist_mode = 1'b1;
                n_dist = regs[R_MASK_AMT];
            end
            ST_COMP: begin
                n_run = comp != '0;
                n_dist_mode = 1'b1;
                n_dir = comp[31] ? DIR_REV : DIR_FWD;
                n_dist = comp[31] ? -comp : comp;
                n_speed = regs[R_COMP_SPD];
            end
            ST_JOG, ST_INCH: begin
                n_dist_mode = state == ST_INCH;
                n_dist = {16'h0000, inch_w};
                n_dir = jog_dir;
                n_speed = jog_speed_sel ? regs[R_JOG_SPD2]
                    : regs[R_JOG_SPD1];
                n_acc = regs[R_JOG_ACC];
                n_dec = regs[R_JOG_DEC];
            end
            ST_RETURN: begin
                n_dist_mode = 1'b1;
                n_dir = pos[31] ? DIR_FWD : DIR_REV;
                n_dist = pos[31] ? -pos : pos;
                n_speed = regs[R_RET_SPD];
                n_acc = regs[R_RET_ACC];
                n_dec = regs[R_RET_DEC];
            end
            default: n_run = state != ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prof_run <= 1'b0;
            prof_dist_mode <= 1'b0;
            prof_dir <= DIR_FWD;
            prof_acc_sel <= 1'b0;
            prof_speed <= '0;
            prof_acc <= '0;
            prof_dec <= '0;
            prof_dist <= '0;
        end else if (ce) begin
            prof_run <= n_run;
            prof_dist_mode <= n_dist_mode;
            prof_dir <= n_dir;
            prof_acc_sel <= regs[R_CTRL][F_ACC_SEL];
            prof_speed <= n_speed;
            prof_acc <= n_acc;
            prof_dec <= n_dec;
            prof_dist <= n_dist;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst || !ce);

    seek_speed_a: assert property (state == ST_SEEK |=> prof_speed
        == $past(regs[R_SEEK_SPD])
        && prof_dir == $past(regs[R_CTRL][F_START_DIR]))
        else $error("search speed or direction wrong");
    approach_speed_a: assert property (state == ST_APPROACH |=> prof_speed
        == $past(regs[R_APPR_SPD]))
        else $error("approach speed wrong");
    comp_speed_a: assert property (state == ST_COMP && comp != '0 |=>
        prof_run && prof_speed == $past(regs[R_COMP_SPD]))
        else $error("compensation speed wrong");
    hold_mode_a: assert property (state == ST_HOLD |-> mode == MODE_HOLD)
        else $error("hold entered in wrong mode");
    mask_mode_a: assert property (state == ST_MASK |-> mode == MODE_MASK)
        else $error("mask feed in wrong mode");
    origin_load_a: assert property (lk.origin_def |=> ##0 lk.present_pos
        == $past(regs[R_ORG_OFS]) && origin_defined)
        else $error("origin offset not loaded");
    inch_zero_a: assert property (state == ST_IDLE && cmd_inch && !cmd_stop
        && !cmd_search && !cmd_return && inch_w == '0 |=> state == ST_JOG)
        else $error("zero inch width did not jog");
    jog_speed_a: assert property (state == ST_JOG |=> prof_speed ==
        ($past(jog_speed_sel) ? $past(regs[R_JOG_SPD2])
        : $past(regs[R_JOG_SPD1])) && prof_acc == $past(regs[R_JOG_ACC]))
        else $error("jog speed or ramp wrong");
    return_live_a: assert property (state == ST_RETURN |=> prof_speed ==
        $past(regs[R_RET_SPD]) && prof_dec == $past(regs[R_RET_DEC]))
        else $error("return profile not live");
    acc_sel_a: assert property (1'b1 |=> prof_acc_sel ==
        $past(regs[R_CTRL][F_ACC_SEL]))
        else $error("ramp selection not passed on");

    seek_done_c: cover property (state == ST_APPROACH ##1 state == ST_COMP);
    hold_c: cover property (state == ST_HOLD ##1 state == ST_APPROACH);
    jog_c: cover property (state == ST_JOG && $changed(jog_speed_sel));
    return_c: cover property (state == ST_RETURN ##1 state == ST_IDLE);
endmodule

/* sim/drive_model.sv */
`timescale 1ns/1ps
module drive_model #(
    parameter int done_delay = 40
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic prof_run,
    input wire logic prof_dist_mode,
    output logic move_done,
    output logic drive_abs_pin,
    output logic [15:0] pos_delta
);
    int cnt;
    // The drive reports an incremental motor, so an absolute unit
    // setting disagrees with it on purpose.
    assign drive_abs_pin = 1'b0;
    // A drive that never moves keeps every position check exact.
    assign pos_delta = 16'h0000;
    always @(posedge clk_sys) begin
        move_done <= 1'b0;
        if (srst || !(prof_run && prof_dist_mode)) begin
            cnt <= 0;
        end else if (cnt == done_delay) begin
            cnt <= 0;
            move_done <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* sim/axis_params_tb_top.sv */
`timescale 1ns/1ps
module axis_params_tb_top;
    import axis_param_pkg::*;
    typedef struct packed {logic [3:0] s; logic [31:0] v;} probe_type;
    logic clk_sys, srst = 1'b1, wr = 1'b0, rd = 1'b0, restart = 1'b0;
    logic cmd_search = 1'b0, cmd_return = 1'b0, cmd_jog = 1'b0;
    logic cmd_inch = 1'b0, jog_speed_sel = 1'b0, prox_pin = 1'b0;
    logic origin_pin = 1'b0, abs_capture = 1'b0, rd_d = 1'b0;
    logic move_done, drive_abs_pin, prof_run, prof_dist_mode, prof_dir;
    logic prof_acc_sel, origin_defined, enc_abs;
    logic [4:0] addr = 5'h00;
    logic [15:0] pos_delta;
    logic [31:0] wdata = 32'h0000_0000, backup_pos = 32'h5a5a_0001;
    logic [31:0] abs_capture_value = 32'h0000_0000, seed = 32'h0001_1c04;
    logic [31:0] rdata, prof_speed, prof_acc, prof_dec, prof_dist;
    logic [31:0] present_pos, abs_offset_active;
    logic [31:0] rq[$];
    probe_type pq[$];
    probe_type p;
    int bad_count = 0, n_tests = 0;
    string nm[11] = '{"speed", "acc", "dist", "pos", "abs_ofs", "run",
        "dist_mode", "dir", "acc_sel", "origin", "enc_abs"};
    logic [3:0] md[3] = '{4'h0, MODE_MASK, MODE_HOLD};

    axis_params #(.cycles_per_ms(4)) dut (.clk_sys, .srst, .ce(1'b1),
        .addr, .wdata, .wr, .rd, .rdata, .restart, .cmd_search,
        .cmd_return, .cmd_jog, .cmd_inch, .cmd_stop(1'b0), .jog_dir(1'b0),
        .jog_speed_sel, .move_done, .prox_pin, .origin_pin, .drive_abs_pin,
        .pos_delta, .backup_pos, .abs_capture, .abs_capture_value,
        .prof_run, .prof_dist_mode, .prof_dir, .prof_acc_sel, .prof_speed,
        .prof_acc, .prof_dec, .prof_dist, .origin_defined, .enc_abs,
        .present_pos, .abs_offset_active);
    drive_model #(.done_delay(40)) drv (.clk_sys, .srst, .prof_run,
        .prof_dist_mode, .move_done, .drive_abs_pin, .pos_delta);

    ////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Speeds must stay positive and within the signed 32-bit range.
    function logic [31:0] spd();
        return (rnd() >> 1) | 32'h0000_0001;
    endfunction
    function logic [31:0] sig(input logic [3:0] s);
        case (s)
            0: sig = prof_speed;
            1: sig = prof_acc;
            2: sig = prof_dist;
            3: sig = present_pos;
            4: sig = abs_offset_active;
            5: sig = {31'h0, prof_run};
            6: sig = {31'h0, prof_dist_mode};
            7: sig = {31'h0, prof_dir};
            8: sig = {31'h0, prof_acc_sel};
            9: sig = {31'h0, origin_defined};
            default: sig = {31'h0, enc_abs};
        endcase
    endfunction
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task stop_test();
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wreg(input logic [4:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        cyc(1);
        wr <= 1'b0;
        cyc(1);
    endtask
    task rreg(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        addr <= a;
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(1);
    endtask
    // The extra edge lets a command's state change reach the profile outputs.
    task chk(input logic [3:0] s, input logic [31:0] e);
        cyc(1);
        pq.push_back({s, e});
        cyc(1);
    endtask
    task wt();
        int k;
        for (k = 0; k < 300 && prof_run !== 1'b0; k++) cyc(1);
        if (k == 300) begin
            bad_count++;
            $display("[FAIL] run expected 0 seen %b", prof_run);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (rd_d)
            cmp("rdata", rq.pop_front(), rdata);
        rd_d <= rd;
    end
    always @(negedge clk_sys) begin
        while (pq.size() > 0) begin
            p = pq.pop_front();
            cmp(nm[p.s], p.v, sig(p.s));
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        cyc(20000);
        bad_count++;
        stop_test();
    end
    initial begin
        logic [31:0] o, v, s, a, c, r, m, w;
        cyc(12);
        srst <= 1'b0;
        for (int i = 2; i < 21; i++) rreg(5'(i), REG_RESET[i]);
        rreg(5'h16, 32'h0000_0000);
        wreg(R_POS, rnd());
        rreg(R_POS, 32'h0000_0000);
        wreg(R_ENC_TYPE, 32'h0000_0001);
        chk(10, 32'h0000_0000);
        wreg(R_CTRL, 32'h0000_0001);
        chk(10, 32'h0000_0001);
        v = rnd();
        backup_pos <= v;
        restart <= 1'b1;
        cyc(1);
        restart <= 1'b0;
        chk(3, v);
        v = rnd();
        abs_capture <= 1'b1;
        abs_capture_value <= v;
        cyc(1);
        abs_capture <= 1'b0;
        chk(4, 32'h0000_0000);
        rreg(R_ABS_OFS, v);
        s = spd();
        a = spd();
        c = spd();
        m = rnd() >> 1;
        wreg(R_SEEK_SPD, s);
        wreg(R_APPR_SPD, a);
        wreg(R_COMP_SPD, c);
        wreg(R_COMP_VAL, 32'h0000_0005);
        wreg(R_HOLD_MS, 32'h0000_0003);
        wreg(R_MASK_AMT, m);
        for (int i = 0; i < 3; i++) begin
            o = spd();
            wreg(R_ORG_OFS, o);
            wreg(R_CTRL, {20'h0_0000, md[i], 8'h08});
            cmd_search <= 1'b1;
            cyc(1);
            cmd_search <= 1'b0;
            chk(0, s);
            chk(7, 32'(DIR_REV));
            prox_pin <= 1'b1;
            cyc(5);
            chk(6, 32'(md[i] == MODE_MASK));
            chk(5, 32'(md[i] != MODE_HOLD));
            if (md[i] == MODE_MASK)
                chk(2, m);
            cyc(60);
            chk(0, a);
            origin_pin <= 1'b1;
            cyc(5);
            chk(3, o);
            chk(4, v);
            chk(0, c);
            prox_pin <= 1'b0;
            origin_pin <= 1'b0;
            wt();
        end
        r = spd();
        wreg(R_RET_SPD, r);
        cmd_return <= 1'b1;
        cyc(1);
        cmd_return <= 1'b0;
        chk(0, r);
        chk(7, 32'(DIR_REV));
        r = spd();
        wreg(R_RET_SPD, r);
        chk(0, r);
        wreg(R_CTRL, 32'h0000_000a);
        chk(8, 32'h0000_0001);
        chk(1, REG_RESET[12]);
        wt();
        cmd_jog <= 1'b1;
        cyc(1);
        chk(0, REG_RESET[15]);
        chk(1, REG_RESET[17]);
        jog_speed_sel <= 1'b1;
        chk(0, REG_RESET[16]);
        cmd_jog <= 1'b0;
        cyc(3);
        cmd_inch <= 1'b1;
        cyc(1);
        chk(5, 32'h0000_0001);
        chk(6, 32'h0000_0000);
        cmd_inch <= 1'b0;
        cyc(3);
        w = (rnd() & 32'h0000_ffff) | 32'h0000_0001;
        wreg(R_INCH_W, w);
        cmd_inch <= 1'b1;
        cyc(1);
        cmd_inch <= 1'b0;
        chk(2, w);
        chk(1, REG_RESET[17]);
        wt();
        wreg(R_CTRL, 32'h0000_0004);
        chk(10, 32'h0000_0000);
        stop_test();
    end
endmodule
